// ### verilog/rst_seq_pkg.sv
// constants for the flash reset sequencing controller
package rst_seq_pkg;
   localparam int unsigned CLK_MHZ = 250;
   // times in their own units, as specified
   localparam int unsigned CORE_SUPPLY_SETTLE_US = 300;
   localparam int unsigned IO_SUPPLY_SETTLE_US = 300;
   localparam int unsigned WARM_RESTART_DURATION_US = 35;
   localparam int unsigned RESTART_PULSE_MIN_NS = 200;
   localparam int unsigned RESTART_HIGH_TO_SELECT_NS = 50;
   localparam int unsigned SELECT_HIGH_PULSE_MIN_NS = 20;
   // minimum times round up to whole cycles
   localparam int unsigned SETTLE_US_MAX =
      (CORE_SUPPLY_SETTLE_US > IO_SUPPLY_SETTLE_US) ?
      CORE_SUPPLY_SETTLE_US : IO_SUPPLY_SETTLE_US;
   localparam int unsigned SETTLE_CYC = SETTLE_US_MAX * CLK_MHZ;
   localparam int unsigned WARM_CYC = WARM_RESTART_DURATION_US * CLK_MHZ;
   localparam int unsigned PULSE_CYC =
      (RESTART_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned RH_CYC =
      (RESTART_HIGH_TO_SELECT_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned CEH_CYC =
      (SELECT_HIGH_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned CNT_W = 20;
   typedef enum logic [5:0] {
      ST_OFF = 6'h01,
      ST_SETTLE = 6'h02,
      ST_PULSE = 6'h04,
      ST_GAP = 6'h08,
      ST_SEL_HI = 6'h10,
      ST_READY = 6'h20
   } seq_state_e;
endpackage : rst_seq_pkg

// ### verilog/flash_rst_host.sv
// host controller that sequences cold and warm reset of a parallel flash
// Behaviour
// - wait 300 us after both supplies good before first access
// - after restart pin falls, keep select high 35 us before select low
// - restart low at least 200 ns; low time plus gap covers warm duration
// - restart high at least 50 ns before select goes low
// - select held high for a pulse of at least 20 ns in sequence
// - restart low at power-on: select waits for settle, then a full warm duration from settle end
// - host holds select and output enable high; the falling edge after cold reset is left to user logic
`timescale 1ns/10ps
module flash_rst_host
   import rst_seq_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic supplies_good,
   input wire logic warm_req,
   input wire logic hold_in_reset,
   input wire logic ready_busy_n,
   output logic restart_n,
   output logic select_n,
   output logic out_en_n,
   output logic access_ok,
   output logic seq_busy
);
   seq_state_e state_r;
   seq_state_e state_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic [CNT_W-1:0] warm_r;
   logic [CNT_W-1:0] warm_nxt;
   logic restart_n_r;
   logic restart_n_nxt;
   logic select_n_r;
   logic select_n_nxt;
   logic access_ok_r;
   logic access_ok_nxt;
   logic busy_r;
   logic busy_nxt;
   // pin run lengths, a second guard on the minimum pin times that holds
   // even if a later change to the sequencer shortens a state
   logic [CNT_W-1:0] lo_run_r;
   logic [CNT_W-1:0] lo_run_nxt;
   logic [CNT_W-1:0] hi_run_r;
   logic [CNT_W-1:0] hi_run_nxt;
   logic [CNT_W-1:0] sel_run_r;
   logic [CNT_W-1:0] sel_run_nxt;

   function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
      cyc = n[CNT_W-1:0];
   endfunction : cyc

   function automatic logic [CNT_W-1:0] inc_sat(input logic [CNT_W-1:0] v);
      if (v == {CNT_W{1'b1}}) begin
         inc_sat = v;
      end else begin
         inc_sat = v + 1'b1;
      end
   endfunction : inc_sat

   // true once a run of n cycles has been seen; n is never zero here
   function automatic logic met(input logic [CNT_W-1:0] v,
                                input int unsigned n);
      met = (v >= cyc(n - 1));
   endfunction : met

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = inc_sat(cnt_r);
      warm_nxt = warm_r;
      restart_n_nxt = restart_n_r;
      select_n_nxt = 1'b1;
      access_ok_nxt = 1'b0;
      busy_nxt = 1'b1;
      // a supply drop restarts everything, device reruns its cold reset
      if (!supplies_good) begin
         state_nxt = ST_OFF;
         cnt_nxt = '0;
         warm_nxt = '0;
         restart_n_nxt = !hold_in_reset;
      end else begin
         case (state_r)
            ST_OFF: begin
               state_nxt = ST_SETTLE;
               cnt_nxt = '0;
               warm_nxt = '0;
            end
            ST_SETTLE: begin
               // restart low here is optional; warm time counted here is dropped at settle end
               if (!restart_n_r) begin
                  warm_nxt = inc_sat(warm_r);
               end
               if (cnt_r >= cyc(SETTLE_CYC - 1)) begin
                  if (!restart_n_r) begin
                     // warm time restarts at settle end
                     state_nxt = ST_PULSE;
                     cnt_nxt = '0;
                     warm_nxt = '0;
                  end else begin
                     state_nxt = ST_SEL_HI;
                     cnt_nxt = '0;
                  end
               end
            end
            ST_PULSE: begin
               restart_n_nxt = 1'b0;
               warm_nxt = inc_sat(warm_r);
               // release once pulse min met and warm time less gap elapsed
               if (cnt_r >= cyc(PULSE_CYC - 1) &&
                   met(lo_run_r, PULSE_CYC) &&
                   warm_r >= cyc(WARM_CYC - RH_CYC - 1) &&
                   !hold_in_reset) begin
                  state_nxt = ST_GAP;
                  restart_n_nxt = 1'b1;
                  cnt_nxt = '0;
               end
            end
            ST_GAP: begin
               warm_nxt = inc_sat(warm_r);
               if (cnt_r >= cyc(RH_CYC - 1) &&
                   warm_r >= cyc(WARM_CYC - 1)) begin
                  state_nxt = ST_SEL_HI;
                  cnt_nxt = '0;
               end
            end
            ST_SEL_HI: begin
               // device must be ready too, a rerun cold reset keeps it busy
               if (cnt_r >= cyc(CEH_CYC - 1) &&
                   met(sel_run_r, CEH_CYC) &&
                   met(hi_run_r, RH_CYC) &&
                   ready_busy_n) begin
                  state_nxt = ST_READY;
                  cnt_nxt = '0;
               end
            end
            default: begin
               // ST_READY: user may now issue the first access
               busy_nxt = 1'b0;
               access_ok_nxt = 1'b1;
               if (warm_req || hold_in_reset) begin
                  state_nxt = ST_PULSE;
                  restart_n_nxt = 1'b0;
                  access_ok_nxt = 1'b0;
                  busy_nxt = 1'b1;
                  cnt_nxt = '0;
                  warm_nxt = '0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         state_r <= ST_OFF;
         cnt_r <= '0;
         warm_r <= '0;
         restart_n_r <= 1'b0;
         select_n_r <= 1'b1;
         access_ok_r <= 1'b0;
         busy_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         warm_r <= warm_nxt;
         restart_n_r <= restart_n_nxt;
         select_n_r <= select_n_nxt;
         access_ok_r <= access_ok_nxt;
         busy_r <= busy_nxt;
      end
   end

   // runs saturate, so a pin parked for a long time still reads as long
   always_comb begin
      lo_run_nxt = lo_run_r;
      hi_run_nxt = hi_run_r;
      sel_run_nxt = sel_run_r;
      if (restart_n_r) begin
         lo_run_nxt = '0;
         hi_run_nxt = inc_sat(hi_run_r);
      end else begin
         lo_run_nxt = inc_sat(lo_run_r);
         hi_run_nxt = '0;
      end
      if (select_n_r) begin
         sel_run_nxt = inc_sat(sel_run_r);
      end else begin
         sel_run_nxt = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         lo_run_r <= '0;
         hi_run_r <= '0;
         sel_run_r <= '0;
      end else begin
         lo_run_r <= lo_run_nxt;
         hi_run_r <= hi_run_nxt;
         sel_run_r <= sel_run_nxt;
      end
   end

   // select and output enable parked high; the user's access logic takes
   // them low only after access_ok, which gives the falling edge needed
   assign restart_n = restart_n_r;
   assign select_n = select_n_r;
   assign out_en_n = select_n_r;
   assign access_ok = access_ok_r;
   assign seq_busy = busy_r;
endmodule : flash_rst_host

// ### testbench/flash_rst_host_sva.sv
// assertions on the reset sequencing controller ports
`timescale 1ns/10ps
module flash_rst_host_sva
   import rst_seq_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic supplies_good,
   input wire logic warm_req,
   input wire logic ready_busy_n,
   input wire logic restart_n,
   input wire logic select_n,
   input wire logic out_en_n,
   input wire logic access_ok
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   int sg_r = 0, lo_r = 0, hi_r = 0, fall_r = 0;
   logic prev_r = 1'b0;
   always_ff @(posedge core_clk) begin
      prev_r <= restart_n;
      sg_r <= (!nrst || !supplies_good) ? 0 : sg_r + 1;
      lo_r <= restart_n ? 0 : lo_r + 1;
      hi_r <= restart_n ? hi_r + 1 : 0;
      fall_r <= (prev_r && !restart_n) ? 1 : fall_r + 1;
   end
   sequence warm_start;
      access_ok && warm_req;
   endsequence
   settle_wait_a: assert property (
      $rose(access_ok) |-> sg_r >= SETTLE_CYC) else $error("early access");
   supply_drop_a: assert property (
      !supplies_good |=> !access_ok) else $error("access with supply low");
   warm_start_a: assert property (
      warm_start |=> !restart_n && !access_ok) else $error("no restart");
   warm_total_a: assert property (
      $rose(access_ok) |-> fall_r >= WARM_CYC) else $error("warm too short");
   pulse_min_a: assert property (
      $rose(restart_n) && sg_r > SETTLE_CYC |-> lo_r >= PULSE_CYC &&
      lo_r + RH_CYC >= WARM_CYC) else $error("restart pulse short");
   high_gap_a: assert property (
      $rose(access_ok) |-> restart_n && hi_r >= RH_CYC) else $error("gap");
   sel_parked_a: assert property (
      !access_ok |-> select_n && out_en_n) else $error("select low");
   ready_seen_a: assert property (
      $rose(access_ok) |-> ready_busy_n) else $error("access while busy");
endmodule : flash_rst_host_sva
bind flash_rst_host flash_rst_host_sva u_flash_rst_host_sva(
   .core_clk(core_clk), .nrst(nrst), .supplies_good(supplies_good),
   .warm_req(warm_req), .ready_busy_n(ready_busy_n),
   .restart_n(restart_n), .select_n(select_n), .out_en_n(out_en_n),
   .access_ok(access_ok));

// ### testbench/flash_dev_model.sv
// behavioural flash device answering the reset pins
`timescale 1ns/10ps
module flash_dev_model
   import rst_seq_pkg::*;
(
   input wire logic core_clk,
   input wire logic supplies_good,
   input wire logic restart_n,
   output logic ready_busy_n
);
   int cnt = 0;
   logic prev_r = 1'b1;
   logic cold_r = 1'b0;
   // pins ignored while a reset algorithm counts down
   always @(posedge core_clk) begin
      prev_r <= restart_n;
      if (!supplies_good) begin
         cnt <= SETTLE_CYC;
         cold_r <= 1'b1;
      end else if (cnt > 0) cnt <= cnt - 1;
      else if (cold_r) begin
         // restart still low at settle end: warm time starts from here
         cold_r <= 1'b0;
         if (!restart_n) cnt <= WARM_CYC;
      end else if (prev_r && !restart_n) cnt <= WARM_CYC;
   end
   assign ready_busy_n = (cnt == 0) && !cold_r;
endmodule : flash_dev_model

// ### testbench/flash_cold_warm_reset_sequencer_tb.sv
// self-checking bench for the flash reset sequencing controller
`timescale 1ns/10ps
module flash_cold_warm_reset_sequencer_tb;
   import rst_seq_pkg::*;
   logic core_clk = 0, nrst = 0, supplies_good = 0, warm_req = 0;
   logic hold_in_reset = 0;
   logic ready_busy_n, restart_n, select_n, out_en_n, access_ok, seq_busy;
   int fail_count = 0, checks_done = 0, n, h;
   logic [31:0] seed = 32'h45f0;
   always #2 core_clk = ~core_clk;
   flash_rst_host u_flash_rst_host(.core_clk(core_clk), .nrst(nrst),
      .supplies_good(supplies_good), .warm_req(warm_req),
      .hold_in_reset(hold_in_reset), .ready_busy_n(ready_busy_n),
      .restart_n(restart_n), .select_n(select_n), .out_en_n(out_en_n),
      .access_ok(access_ok), .seq_busy(seq_busy));
   flash_dev_model u_flash_dev_model(.core_clk(core_clk),
      .supplies_good(supplies_good), .restart_n(restart_n),
      .ready_busy_n(ready_busy_n));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   // a held restart stretches the wait past the warm duration
   function automatic int exp_min(input int hold);
      return ((hold + RH_CYC > WARM_CYC) ? hold + RH_CYC : WARM_CYC) + CEH_CYC;
   endfunction : exp_min
   task chk(input logic ok, input string m);
      checks_done++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("ERROR at %0t: %s", $time, m);
      end
   endtask : chk
   task wait_ok(output int c);
      c = 0;
      while (access_ok !== 1'b1 && c < 90000) begin
         @(negedge core_clk);
         c++;
      end
      chk(access_ok === 1'b1, "access never granted");
   endtask : wait_ok
   task results;
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : results
   initial begin
      repeat (96000) @(posedge core_clk);
      fail_count++;
      results();
   end
   initial begin
      repeat (10) @(negedge core_clk);
      nrst = 1;
      @(negedge core_clk);
      supplies_good = 1;
      wait_ok(n);
      chk(n >= SETTLE_CYC + CEH_CYC, "access before settle");
      chk(select_n & out_en_n, "select not parked");
      chk(seq_busy === 1'b0, "busy after sequence");
      for (int i = 0; i < 2; i++) begin
         seed = xs(seed);
         repeat (seed[3:0] + 1) @(negedge core_clk);
         h = i ? WARM_CYC + seed[7:0] : 0;
         warm_req = 1;
         hold_in_reset = (i == 1);
         @(negedge core_clk);
         warm_req = 0;
         chk(!restart_n & !access_ok, "restart not driven");
         chk(seq_busy === 1'b1, "busy not raised");
         repeat (h) @(negedge core_clk);
         chk(h == 0 || restart_n === 1'b0, "restart released");
         hold_in_reset = 0;
         wait_ok(n);
         chk(n + h + 1 >= exp_min(h), "select too early");
      end
      supplies_good = 0;
      repeat (2) @(negedge core_clk);
      chk(access_ok === 1'b0, "access kept at supply loss");
      results();
   end
endmodule : flash_cold_warm_reset_sequencer_tb
